// [icu_pkg.sv]
// Purpose: Shared constants for the card UART ETU and configuration block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Register indices are multiplied by four to form byte addresses
package icu_pkg;
  localparam logic [7:0] ICU_IDX_ETU_DIVIDER = 8'h02;
  localparam logic [7:0] ICU_IDX_CONFIG_B = 8'h03;
  localparam logic [7:0] ICU_IDX_CONFIG_A = 8'h06;
  localparam logic [7:0] ICU_IDX_CTRL = 8'h10;
  localparam logic [7:0] ICU_IDX_STATUS = 8'h11;
  localparam logic [11:0] ICU_ADDR_ETU_DIVIDER = {2'b00, ICU_IDX_ETU_DIVIDER, 2'b00};
  localparam logic [11:0] ICU_ADDR_CONFIG_B = {2'b00, ICU_IDX_CONFIG_B, 2'b00};
  localparam logic [11:0] ICU_ADDR_CONFIG_A = {2'b00, ICU_IDX_CONFIG_A, 2'b00};
  localparam logic [11:0] ICU_ADDR_CTRL = {2'b00, ICU_IDX_CTRL, 2'b00};
  localparam logic [11:0] ICU_ADDR_STATUS = {2'b00, ICU_IDX_STATUS, 2'b00};
  localparam logic [7:0] ICU_RST_ETU_DIVIDER = 8'h00;
  localparam logic [7:0] ICU_RST_CONFIG_B = 8'h00;
  localparam logic [7:0] ICU_RST_CONFIG_A = 8'h00;
  localparam logic [7:0] ICU_CFGB_MASK = 8'hdf;
  localparam logic [7:0] ICU_CFGA_MASK = 8'h7f;
  localparam int ICU_B_EXT_WAKE = 7;
  localparam int ICU_B_BUF_IRQ_DIS = 6;
  localparam int ICU_B_HOST_WAKE = 4;
  localparam int ICU_B_SYNC_CARD = 3;
  localparam int ICU_B_MANUAL_CONVENTION_BIT = 2;
  localparam int ICU_B_HALF_ETU = 1;
  localparam int ICU_B_PRESCALER = 0;
  localparam int ICU_A_SESSION = 1;
  localparam int ICU_A_CONVENTION_BIT = 0;
  localparam logic [5:0] ICU_PRESCALE_31 = 6'h1f;
  localparam logic [5:0] ICU_PRESCALE_32 = 6'h20;
  // Half ETU steps from the start edge of the initial character before session start clears (10.5 ETU)
  localparam logic [4:0] ICU_SESSION_HALF_ETUS = 5'h15;
  // Initial character pattern after sampling bits in line order (direct convention)
  localparam logic [7:0] ICU_TS_DIRECT = 8'h3b;
  localparam logic [7:0] ICU_TS_INVERSE = 8'hc0;
  localparam logic [31:0] ICU_SLVERR_NONE = 32'h0;
  typedef enum logic [3:0] {
    ICU_RX_IDLE = 4'b0001,
    ICU_RX_START = 4'b0010,
    ICU_RX_DATA = 4'b0100,
    ICU_RX_HOLD = 4'b1000
  } icu_rx_state_e;
endpackage : icu_pkg

// [icu_sync2.sv]
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Input asynchronous to mclk_in
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module icu_sync2 (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  logic sync_r;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end
  assign sync_out = sync_r;
endmodule : icu_sync2
`default_nettype wire

// [icu_etu_gen.sv]
// Purpose: ETU divider and prescaler time base
// Assumes: Card clock enable pulses in mclk_in domain
// Notes: Emits half-ETU and ETU ticks
`timescale 1ns/1ps
`default_nettype none
module icu_etu_gen
  import icu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic card_clk_en_in,
  input wire logic [7:0] divider_value_in,
  input wire logic prescaler_sel_in,
  input wire logic half_etu_unit_in,
  input wire logic clk_is_xtal_in,
  output logic half_tick_out,
  output logic etu_tick_out
);
  logic [5:0] psc_cnt_r;
  logic [7:0] div_cnt_r;
  logic [5:0] psc_top;
  logic psc_wrap;
  logic div_wrap;
  logic halve;
  assign psc_top = prescaler_sel_in ? ICU_PRESCALE_32 : ICU_PRESCALE_31;
  assign halve = half_etu_unit_in && !clk_is_xtal_in;
  // Halved ETU runs the prescaler at double rate by counting two per card clock
  assign psc_wrap = card_clk_en_in && (halve ? (psc_cnt_r >= psc_top - 6'd2)
                                             : (psc_cnt_r == psc_top - 6'd1));
  assign div_wrap = psc_wrap && (div_cnt_r <= 8'h1);
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      psc_cnt_r <= 6'h0;
    end else if (psc_wrap) begin
      psc_cnt_r <= (halve && psc_cnt_r == psc_top - 6'd1) ? 6'h1 : 6'h0;
    end else if (card_clk_en_in) begin
      psc_cnt_r <= psc_cnt_r + (halve ? 6'd2 : 6'd1);
    end
  end
  // Auto-reload down-counter, ETU = prescaler x divider
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt_r <= 8'h0;
    end else if (div_wrap) begin
      div_cnt_r <= divider_value_in;
    end else if (psc_wrap) begin
      div_cnt_r <= div_cnt_r - 8'h1;
    end
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      half_tick_out <= 1'b0;
      etu_tick_out <= 1'b0;
    end else begin
      // Mid tick on the prescaler wrap that leaves half the divider count
      half_tick_out <= psc_wrap
                       && (div_wrap || div_cnt_r == {1'b0, divider_value_in[7:1]} + 8'h1);
      etu_tick_out <= div_wrap && divider_value_in != 8'h0;
    end
  end
endmodule : icu_etu_gen
`default_nettype wire

// [icu_card_uart.sv]
// Purpose: ETU timing and configuration of a smart-card UART
// Assumes: APB slave, 40 MHz mclk_in, card clock given as enable pulses
// Notes: Character engine kept minimal: initial character and convention
`timescale 1ns/1ps
`default_nettype none
module icu_card_uart
  import icu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_clk_en_in,
  input wire logic clk_is_xtal_in,
  input wire logic sync_clock_ctrl_in,
  input wire logic power_down_in,
  input wire logic ext_irq_pin_n_in,
  input wire logic host_rx_pin_in,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe_out,
  output logic card_clk_gate_out,
  input wire logic char_event_in,
  input wire logic status_event_in,
  output logic wake_out,
  output logic char_irq_out,
  output logic status_irq_out,
  output logic etu_tick_out,
  output logic half_tick_out,
  input wire logic [7:0] tx_register_in,
  output logic [7:0] rx_register_out
);
  import icu_pkg::*;
  logic [7:0] etu_divider_r;
  logic [7:0] card_uart_config_b_r;
  logic session_r;
  logic convention_bit_r;
  logic ext_sync;
  logic host_sync;
  logic io_sync;
  logic ext_d_r;
  logic host_d_r;
  logic io_d_r;
  logic wake_r;
  logic [7:0] rx_register_r;
  icu_rx_state_e rx_state_r;
  logic [3:0] bit_cnt_r;
  logic [4:0] half_cnt_r;
  logic [7:0] shift_r;
  logic ts_done_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic manual_convention_bit;
  logic sync_card;

  icu_sync2 u_ext_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(ext_irq_pin_n_in),
    .sync_out(ext_sync)
  );
  icu_sync2 u_host_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(host_rx_pin_in),
    .sync_out(host_sync)
  );
  icu_sync2 u_io_sync (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(card_io_in),
    .sync_out(io_sync)
  );

  icu_etu_gen u_etu (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .card_clk_en_in(card_clk_en_in),
    .divider_value_in(etu_divider_r),
    .prescaler_sel_in(card_uart_config_b_r[ICU_B_PRESCALER]),
    .half_etu_unit_in(card_uart_config_b_r[ICU_B_HALF_ETU]),
    .clk_is_xtal_in(clk_is_xtal_in),
    .half_tick_out(half_tick_out),
    .etu_tick_out(etu_tick_out)
  );

  assign manual_convention_bit = card_uart_config_b_r[ICU_B_MANUAL_CONVENTION_BIT];
  assign sync_card = card_uart_config_b_r[ICU_B_SYNC_CARD];

  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  always_comb begin
    if (paddr == ICU_ADDR_ETU_DIVIDER) begin
      addr_ok = 1'b1;
    end else if (paddr == ICU_ADDR_CONFIG_B) begin
      addr_ok = 1'b1;
    end else if (paddr == ICU_ADDR_CONFIG_A) begin
      addr_ok = 1'b1;
    end else if (paddr == ICU_ADDR_STATUS) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end
  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prdata <= ICU_SLVERR_NONE;
    end else if (rd_en) begin
      if (paddr == ICU_ADDR_ETU_DIVIDER) begin
        prdata <= {24'h0, etu_divider_r};
      end else if (paddr == ICU_ADDR_CONFIG_B) begin
        prdata <= {24'h0, card_uart_config_b_r};
      end else if (paddr == ICU_ADDR_CONFIG_A) begin
        prdata <= {30'h0, session_r, convention_bit_r};
      end else if (paddr == ICU_ADDR_STATUS) begin
        prdata <= {24'h0, rx_state_r, ts_done_r, wake_r, io_sync, rx_register_r[0]};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      etu_divider_r <= ICU_RST_ETU_DIVIDER;
    end else if (wr_en && paddr == ICU_ADDR_ETU_DIVIDER) begin
      etu_divider_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      card_uart_config_b_r <= ICU_RST_CONFIG_B;
    end else if (wr_en && paddr == ICU_ADDR_CONFIG_B) begin
      card_uart_config_b_r <= pwdata[7:0] & ICU_CFGB_MASK;
    end
  end

  // Session start: hardware clear wins over a software write in the same cycle
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      session_r <= 1'b0;
    end else if (rx_state_r == ICU_RX_HOLD && half_tick_out
                 && half_cnt_r == ICU_SESSION_HALF_ETUS - 5'd1) begin
      session_r <= 1'b0;
    end else if (wr_en && paddr == ICU_ADDR_CONFIG_A) begin
      session_r <= pwdata[ICU_A_SESSION];
    end
  end

  // Convention bit: detection only in automatic mode, software write only in manual mode
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      convention_bit_r <= 1'b0;
    end else if (!manual_convention_bit && session_r && rx_state_r == ICU_RX_DATA
                 && etu_tick_out && bit_cnt_r == 4'd7) begin
      convention_bit_r <= ({shift_r[6:0], io_sync} == ICU_TS_DIRECT);
    end else if (manual_convention_bit && wr_en && paddr == ICU_ADDR_CONFIG_A) begin
      convention_bit_r <= pwdata[ICU_A_CONVENTION_BIT];
    end
  end

  // Initial character capture, timed by ETU ticks
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_state_r <= ICU_RX_IDLE;
      bit_cnt_r <= 4'h0;
      half_cnt_r <= 5'h0;
      shift_r <= 8'h0;
      ts_done_r <= 1'b0;
    end else begin
      case (rx_state_r)
        ICU_RX_IDLE: begin
          if (session_r && !sync_card && io_d_r && !io_sync) begin
            rx_state_r <= ICU_RX_START;
            half_cnt_r <= 5'h0;
          end
        end
        ICU_RX_START: begin
          if (etu_tick_out) begin
            rx_state_r <= ICU_RX_DATA;
            bit_cnt_r <= 4'h0;
            half_cnt_r <= 5'h2;
          end
        end
        ICU_RX_DATA: begin
          if (etu_tick_out) begin
            shift_r <= {shift_r[6:0], io_sync};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'd7) begin
              rx_state_r <= ICU_RX_HOLD;
              ts_done_r <= 1'b1;
            end
          end
          if (half_tick_out) begin
            half_cnt_r <= half_cnt_r + 5'h1;
          end
        end
        ICU_RX_HOLD: begin
          if (half_tick_out) begin
            half_cnt_r <= half_cnt_r + 5'h1;
          end
          if (!session_r) begin
            rx_state_r <= ICU_RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= ICU_RX_IDLE;
        end
      endcase
    end
  end

  // Falling-edge detect for wake pins and card line
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ext_d_r <= 1'b1;
      host_d_r <= 1'b1;
      io_d_r <= 1'b1;
    end else begin
      ext_d_r <= ext_sync;
      host_d_r <= host_sync;
      io_d_r <= io_sync;
    end
  end

  // Wake pulse only while powered down; waking frame start is not kept
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= power_down_in &&
        ((card_uart_config_b_r[ICU_B_EXT_WAKE] && ext_d_r && !ext_sync) ||
         (card_uart_config_b_r[ICU_B_HOST_WAKE] && host_d_r && !host_sync));
    end
  end
  assign wake_out = wake_r;

  // Character interrupts gated, status interrupts pass
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      char_irq_out <= 1'b0;
      status_irq_out <= 1'b0;
    end else begin
      char_irq_out <= char_event_in && !card_uart_config_b_r[ICU_B_BUF_IRQ_DIS];
      status_irq_out <= status_event_in;
    end
  end

  // Synchronous card bypass of bit 0
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_register_r <= 8'h0;
      card_io_out <= 1'b1;
      card_io_oe_out <= 1'b0;
      card_clk_gate_out <= 1'b0;
    end else begin
      if (sync_card) begin
        rx_register_r <= {7'h0, io_sync};
        card_io_out <= tx_register_in[0];
        card_io_oe_out <= !tx_register_in[0];
        card_clk_gate_out <= sync_clock_ctrl_in;
      end else begin
        rx_register_r <= shift_r;
        card_io_out <= 1'b1;
        card_io_oe_out <= 1'b0;
        card_clk_gate_out <= card_clk_en_in;
      end
    end
  end
  assign rx_register_out = rx_register_r;
endmodule : icu_card_uart
`default_nettype wire

// [icu_card_uart_sva.sv]
// Purpose: Port-level assertions for the card UART block
// Assumes: Config B mirrored from APB writes, pready high
// Notes: Bound to icu_card_uart
`timescale 1ns/1ps
`default_nettype none
module icu_card_uart_sva
  import icu_pkg::*;
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic card_clk_en_in,
  input wire logic sync_clock_ctrl_in,
  input wire logic power_down_in,
  input wire logic [7:0] tx_register_in,
  input wire logic card_io_oe_out,
  input wire logic card_clk_gate_out,
  input wire logic char_event_in,
  input wire logic status_event_in,
  input wire logic wake_out,
  input wire logic char_irq_out,
  input wire logic status_irq_out,
  input wire logic etu_tick_out,
  input wire logic half_tick_out
);
  logic [7:0] cfgb_r;
  logic live_r;
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfgb_r <= ICU_RST_CONFIG_B;
    end else if (psel && penable && pwrite && paddr == ICU_ADDR_CONFIG_B) begin
      cfgb_r <= pwdata[7:0] & ICU_CFGB_MASK;
    end
  end
  // Skips the first edge after reset, whose past inputs are reset-time values
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      live_r <= 1'h0;
    end else begin
      live_r <= 1'h1;
    end
  end
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  AST_ERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  AST_STAT_IRQ: assert property (live_r |-> status_irq_out == $past(status_event_in))
    else $error("status irq not following its event");
  AST_CHAR_IRQ: assert property (live_r |-> char_irq_out ==
    ($past(char_event_in) && !$past(cfgb_r[ICU_B_BUF_IRQ_DIS])))
    else $error("char irq wrong for disable bit");
  AST_WAKE_PD: assert property (wake_out |-> $past(power_down_in))
    else $error("wake outside power down");
  AST_WAKE_EN: assert property (wake_out |->
    $past(cfgb_r[ICU_B_EXT_WAKE]) || $past(cfgb_r[ICU_B_HOST_WAKE]))
    else $error("wake with no enable");
  AST_IO_OE: assert property (live_r |-> card_io_oe_out ==
    ($past(cfgb_r[ICU_B_SYNC_CARD]) && !$past(tx_register_in[0])))
    else $error("io drive wrong");
  AST_CLK_GATE: assert property (live_r |-> card_clk_gate_out ==
    ($past(cfgb_r[ICU_B_SYNC_CARD]) ? $past(sync_clock_ctrl_in) : $past(card_clk_en_in)))
    else $error("card clock source wrong");
  AST_ETU_PULSE: assert property (etu_tick_out |=> !etu_tick_out [*8])
    else $error("etu tick too long");
  AST_HALF_WITH_ETU: assert property (etu_tick_out |-> half_tick_out)
    else $error("etu tick without half tick");
  COV_ETU: cover property (etu_tick_out);
  COV_WAKE: cover property (wake_out);
  COV_SYNC: cover property (card_io_oe_out);
endmodule : icu_card_uart_sva
bind icu_card_uart icu_card_uart_sva u_sva (.mclk_in, .sys_rst_in, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .card_clk_en_in, .sync_clock_ctrl_in, .power_down_in,
  .tx_register_in, .card_io_oe_out, .card_clk_gate_out, .char_event_in, .status_event_in,
  .wake_out, .char_irq_out, .status_irq_out, .etu_tick_out, .half_tick_out);
`default_nettype wire

// [icu_card_model.sv]
// Purpose: Smart card on the I/O line
// Assumes: Line pulled up when the card releases it
// Notes: Bit length given in clock cycles by the caller
`timescale 1ns/1ps
`default_nettype none
module icu_card_model (
  input wire logic mclk_in,
  output logic io_out
);
  initial io_out = 1'h1;
  // Start low, data first bit first, even parity, then release
  task automatic send(input logic [7:0] d, input int etu);
    logic [9:0] f;
    f = {^d, d, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_in);
      io_out <= f[i];
      repeat (etu - 1) @(posedge mclk_in);
    end
    @(posedge mclk_in);
    io_out <= 1'h1;
  endtask : send
  task automatic drive(input logic v);
    @(posedge mclk_in);
    io_out <= v;
  endtask : drive
endmodule : icu_card_model
`default_nettype wire

// [tb_iso_card_uart_etu_config.sv]
// Purpose: Self-checking bench for the card UART block
// Assumes: Card clock enable high every cycle unless randomised
// Notes: Fixed-seed xorshift stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_iso_card_uart_etu_config;
  import icu_pkg::*;
  logic mclk_in = 1'h0, sys_rst_in = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h8f8bedb0;
  logic pready, pslverr, perr, card_io_in, card_line, card_io_out, card_io_oe_out;
  logic card_clk_gate_out, wake_out, char_irq_out, status_irq_out, etu_tick_out, half_tick_out;
  logic card_clk_en_in = 1'h0, clk_is_xtal_in = 1'h0, sync_clock_ctrl_in = 1'h0;
  logic power_down_in = 1'h0, ext_irq_pin_n_in = 1'h1, host_rx_pin_in = 1'h1;
  logic char_event_in = 1'h0, status_event_in = 1'h0;
  logic [7:0] tx_register_in = 8'hff, rx_register_out;
  int err_total = 0, n_tests = 0, cyc = 0;
  assign card_io_in = (card_io_oe_out === 1'h1 && card_io_out === 1'h0) ? 1'h0 : card_line;
  icu_card_uart dut (.mclk_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .card_clk_en_in, .clk_is_xtal_in, .sync_clock_ctrl_in,
    .power_down_in, .ext_irq_pin_n_in, .host_rx_pin_in, .card_io_in, .card_io_out,
    .card_io_oe_out, .card_clk_gate_out, .char_event_in, .status_event_in, .wake_out,
    .char_irq_out, .status_irq_out, .etu_tick_out, .half_tick_out, .tx_register_in,
    .rx_register_out);
  icu_card_model card (.mclk_in, .io_out(card_line));
  initial forever #12.5 mclk_in = ~mclk_in;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int etu_exp(input logic [7:0] d, input logic p, h, x);
    int e;
    e = (p ? 32 : 31) * d;
    return (h && !x) ? e / 2 : e;
  endfunction : etu_exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'h1;
    @(posedge mclk_in);
    while (pready !== 1'h1) @(posedge mclk_in);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic tick_gap(output int n);
    for (int j = 0; j < 3; j++) begin
      n = 0;
      do begin
        @(negedge mclk_in);
        n++;
      end while (etu_tick_out !== 1'h1 && n < 9000);
    end
  endtask : tick_gap
  task automatic close_out;
    $display("mismatches %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    logic [7:0] d;
    int n;
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'h0;
    card_clk_en_in <= 1'h1;
    apb(1'h0, ICU_ADDR_ETU_DIVIDER, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, ICU_ADDR_CONFIG_B, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 12'h100, 32'h0);
    chk(32'(perr), 32'h1);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      apb(1'h1, ICU_ADDR_ETU_DIVIDER, seed);
      apb(1'h0, ICU_ADDR_ETU_DIVIDER, 32'h0);
      chk(rd, {24'h0, seed[7:0]});
      apb(1'h1, ICU_ADDR_CONFIG_B, seed >> 8);
      apb(1'h0, ICU_ADDR_CONFIG_B, 32'h0);
      chk(rd, {24'h0, seed[15:8] & ICU_CFGB_MASK});
    end
    // Every prescaler, half unit and crystal combination; full-scale divider first
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      d = (c == 0) ? 8'hff : {3'h0, seed[3:0], 1'h0} + 8'h2;
      clk_is_xtal_in <= c[2];
      apb(1'h1, ICU_ADDR_ETU_DIVIDER, {24'h0, d});
      apb(1'h1, ICU_ADDR_CONFIG_B, {30'h0, c[1], c[0]});
      tick_gap(n);
      chk(n, etu_exp(d, c[0], c[1], c[2]));
    end
    clk_is_xtal_in <= 1'h0;
    apb(1'h1, ICU_ADDR_ETU_DIVIDER, 32'h2);
    for (int k = 0; k < 3; k++) begin
      apb(1'h1, ICU_ADDR_CONFIG_B, k == 2 ? 32'h4 : 32'h0);
      apb(1'h1, ICU_ADDR_CONFIG_A, 32'h2);
      // Start bit right after a tick; 8'hdc puts the direct pattern on the line first bit first
      do begin
        @(negedge mclk_in);
      end while (etu_tick_out !== 1'h1);
      card.send(k == 1 ? 8'h03 : 8'hdc, 62);
      repeat (186) @(posedge mclk_in);
      apb(1'h0, ICU_ADDR_CONFIG_A, 32'h0);
      chk(32'(rd[0]), k == 0 ? 32'h1 : 32'h0);
      chk(32'(rd[1]), 32'h0);
    end
    apb(1'h1, ICU_ADDR_CONFIG_A, 32'h1);
    apb(1'h0, ICU_ADDR_CONFIG_A, 32'h0);
    chk(32'(rd[0]), 32'h1);
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, ICU_ADDR_CONFIG_B, i[1] ? (i[0] ? 32'h10 : 32'h80) : 32'h0);
      power_down_in <= i[2];
      n = 0;
      @(posedge mclk_in);
      if (i[0]) host_rx_pin_in <= 1'h0;
      else ext_irq_pin_n_in <= 1'h0;
      repeat (12) begin
        @(negedge mclk_in);
        n += int'(wake_out === 1'h1);
      end
      @(posedge mclk_in);
      host_rx_pin_in <= 1'h1;
      ext_irq_pin_n_in <= 1'h1;
      repeat (6) @(posedge mclk_in);
      chk(32'(n != 0), 32'(i[1] && i[2]));
    end
    power_down_in <= 1'h0;
    apb(1'h1, ICU_ADDR_CONFIG_B, 32'h8);
    for (int v = 0; v < 2; v++) begin
      card.drive(v[0]);
      repeat (8) @(posedge mclk_in);
      chk(32'(rx_register_out[0]), 32'(v[0]));
    end
    chk(32'(card_clk_gate_out), 32'h0);
    tx_register_in <= 8'hfe;
    repeat (4) @(posedge mclk_in);
    chk(32'({card_io_oe_out, card_io_out}), 32'h2);
    // Random events and clocks under each sync and irq-disable setting
    for (int r = 0; r < 4; r++) begin
      apb(1'h1, ICU_ADDR_CONFIG_B, {25'h0, r[0], 2'h0, r[1], 3'h0});
      for (int j = 0; j < 40; j++) begin
        @(posedge mclk_in);
        seed = xs(seed);
        char_event_in <= seed[0];
        status_event_in <= seed[1];
        sync_clock_ctrl_in <= seed[2];
        card_clk_en_in <= seed[3];
        tx_register_in <= seed[11:4];
      end
    end
    close_out();
  end
endmodule : tb_iso_card_uart_etu_config
`default_nettype wire
